// *** fmh_pkg.sv ***
// Package for the flash module host controller
package fmh_pkg;
  localparam int ADDR_W          = 20;
  localparam int DATA_W          = 32;
  localparam int HALF_W          = 16;
  localparam int BLOCK_SEL_LSB   = 16;
  localparam int BLOCK_SEL_W     = 4;
  localparam int NUM_DIES        = 2;
  localparam logic [19:0] UNLOCK_ADDR_1 = 20'h0_5555;
  localparam logic [19:0] UNLOCK_ADDR_2 = 20'h0_2AAA;
  localparam logic [7:0]  UNLOCK_DATA_1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA_2 = 8'h55;
  localparam logic [7:0]  CMD_READ_RESET = 8'hF0;
  localparam logic [7:0]  CMD_READ_ID    = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
  localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0]  CMD_ERASE_SUSPEND = 8'hB0;
  localparam logic [3:0]  SETUP_CYCLES  = 4'h2;
  localparam logic [3:0]  STROBE_CYCLES = 4'h4;
  localparam logic [3:0]  HOLD_CYCLES   = 4'h2;

  typedef enum logic [2:0] {
    OP_READ       = 3'h0,
    OP_WRITE      = 3'h1,
    OP_PROGRAM    = 3'h2,
    OP_SECTOR_ERASE = 3'h3,
    OP_CHIP_ERASE = 3'h4,
    OP_SUSPEND    = 3'h5,
    OP_READ_ID    = 3'h6,
    OP_READ_RESET = 3'h7
  } fmh_op_e;

  typedef struct packed {
    fmh_op_e             op;
    logic                wide;
    logic                die;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } fmh_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic                write;
    logic [NUM_DIES-1:0] sel;
  } fmh_cycle_s;
endpackage : fmh_pkg

// *** fmh_cycle.sv ***
// One asynchronous bus cycle on the flash module pins
`timescale 1ns/10ps
`default_nettype none
module fmh_cycle (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire fmh_pkg::fmh_cycle_s cyc,
  input  wire logic [31:0]      dq_in,
  output logic                  done,
  output logic [31:0]           rdata,
  output logic [19:0]           addr_o,
  output logic [31:0]           dq_out,
  output logic                  dq_oe_n,
  output logic [1:0]            sel_n,
  output logic                  we_n,
  output logic                  oe_n
);
  typedef enum logic [3:0] {
    CY_IDLE   = 4'b0001,
    CY_SETUP  = 4'b0010,
    CY_STROBE = 4'b0100,
    CY_HOLD   = 4'b1000
  } fmh_cy_e;

  fmh_cy_e      state_reg;
  logic [3:0]   cnt_reg;
  logic         wr_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CY_IDLE;
      cnt_reg   <= 4'h0;
      wr_reg    <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        CY_IDLE: begin
          if (start) begin
            state_reg <= CY_SETUP;
            cnt_reg   <= fmh_pkg::SETUP_CYCLES;
            wr_reg    <= cyc.write;
          end
        end
        CY_SETUP: begin
          if (cnt_reg == 4'h1) begin
            state_reg <= CY_STROBE;
            cnt_reg   <= fmh_pkg::STROBE_CYCLES;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        CY_STROBE: begin
          if (cnt_reg == 4'h1) begin
            state_reg <= CY_HOLD;
            cnt_reg   <= fmh_pkg::HOLD_CYCLES;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        CY_HOLD: begin
          if (cnt_reg == 4'h1) begin
            state_reg <= CY_IDLE;
            done      <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
      endcase
    end
  end

  // Address and select held stable over the whole cycle so the die latches a settled address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_o  <= 20'h0_0000;
      dq_out  <= 32'h0000_0000;
      sel_n   <= 2'b11;
      dq_oe_n <= 1'b1;
    end else if (start && state_reg == CY_IDLE) begin
      addr_o  <= cyc.addr;
      dq_out  <= cyc.data;
      sel_n   <= ~cyc.sel;
      dq_oe_n <= ~cyc.write;
    end else if (done) begin
      sel_n   <= 2'b11;
      dq_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      we_n <= !(state_reg == CY_SETUP && cnt_reg == 4'h1 && wr_reg)
              && !(state_reg == CY_STROBE && cnt_reg != 4'h1 && wr_reg);
      oe_n <= !(state_reg == CY_SETUP && cnt_reg == 4'h1 && !wr_reg)
              && !(state_reg == CY_STROBE && cnt_reg != 4'h1 && !wr_reg);
    end
  end

  // Sample at strobe end, after access time has elapsed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (state_reg == CY_STROBE && cnt_reg == 4'h1 && !wr_reg) begin
      rdata <= dq_in;
    end
  end
endmodule : fmh_cycle
`default_nettype wire

// *** fmh_host.sv ***
// Host controller driving the flash module pins
// Operation
// - Host drives command codes on data lines
// - Select low accesses die; edges frame cycle
// - Low write strobe performs command write
// - Low output gate obtains read data
`timescale 1ns/10ps
`default_nettype none
module fmh_host #(
  parameter int MAX_SEQ = 6
) (
  input  wire logic                 CLOCK,
  input  wire logic                 RESET_N,
  input  wire logic                 REQ_VALID,
  output logic                      REQ_READY,
  input  wire fmh_pkg::fmh_req_s    REQ,
  output logic                      RSP_VALID,
  output logic [31:0]               RSP_DATA,
  output logic                      BUSY,
  output logic [19:0]               ADDR,
  input  wire logic [31:0]          DQ_IN,
  output logic [31:0]               DQ_OUT,
  output logic                      DQ_OE_N,
  output logic [1:0]                DIE_SELECT_N_PAIR,
  output logic                      WRITE_N,
  output logic                      GATE_N
);
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_ISSUE = 4'b0010,
    HS_WAIT = 4'b0100,
    HS_DONE = 4'b1000
  } fmh_hs_e;

  fmh_hs_e             state_reg;
  fmh_pkg::fmh_req_s   req_reg;
  logic [2:0]          step_reg;
  logic [2:0]          steps;
  logic                cyc_start;
  logic                cyc_done;
  logic [31:0]         cyc_rdata;
  fmh_pkg::fmh_cycle_s cyc;
  logic                busy_reg;

  // Byte command replicated onto both 16-bit halves so either die sees it
  function automatic logic [31:0] fmh_cmd(input logic [7:0] c);
    fmh_cmd = {8'h00, c, 8'h00, c};
  endfunction : fmh_cmd

  // Sequence length per operation
  always_comb begin
    unique case (req_reg.op)
      fmh_pkg::OP_READ, fmh_pkg::OP_WRITE:     steps = 3'h1;
      fmh_pkg::OP_SUSPEND:                     steps = 3'h1;
      fmh_pkg::OP_PROGRAM:                     steps = 3'h4;
      fmh_pkg::OP_READ_ID, fmh_pkg::OP_READ_RESET: steps = 3'h3;
      default:                                 steps = 3'(MAX_SEQ); // Erase is the longest
    endcase
  end

  // Cycle contents for each step of the sequence
  always_comb begin
    cyc.sel   = req_reg.wide ? 2'b11 : (req_reg.die ? 2'b10 : 2'b01);
    cyc.write = 1'b1;
    cyc.addr  = fmh_pkg::UNLOCK_ADDR_1;
    cyc.data  = fmh_cmd(fmh_pkg::UNLOCK_DATA_1);
    if (req_reg.op == fmh_pkg::OP_READ) begin
      cyc.write = 1'b0;
      cyc.addr  = req_reg.addr;
    end else if (req_reg.op == fmh_pkg::OP_WRITE) begin
      cyc.addr  = req_reg.addr;
      cyc.data  = req_reg.data;
    end else if (req_reg.op == fmh_pkg::OP_SUSPEND) begin
      cyc.data  = fmh_cmd(fmh_pkg::CMD_ERASE_SUSPEND);
    end else begin
      unique case (step_reg)
        3'h0, 3'h3: begin
          cyc.addr = fmh_pkg::UNLOCK_ADDR_1;
          cyc.data = fmh_cmd(fmh_pkg::UNLOCK_DATA_1);
        end
        3'h1, 3'h4: begin
          cyc.addr = fmh_pkg::UNLOCK_ADDR_2;
          cyc.data = fmh_cmd(fmh_pkg::UNLOCK_DATA_2);
        end
        default: begin
          cyc.addr = fmh_pkg::UNLOCK_ADDR_1;
          cyc.data = fmh_cmd(fmh_pkg::CMD_ERASE_SETUP);
        end
      endcase
      if (step_reg == 3'h2) begin
        unique case (req_reg.op)
          fmh_pkg::OP_PROGRAM:    cyc.data = fmh_cmd(fmh_pkg::CMD_PROGRAM);
          fmh_pkg::OP_READ_ID:    cyc.data = fmh_cmd(fmh_pkg::CMD_READ_ID);
          fmh_pkg::OP_READ_RESET: cyc.data = fmh_cmd(fmh_pkg::CMD_READ_RESET);
          default:                cyc.data = fmh_cmd(fmh_pkg::CMD_ERASE_SETUP);
        endcase
      end
      if (step_reg == 3'h3 && req_reg.op == fmh_pkg::OP_PROGRAM) begin
        cyc.addr = req_reg.addr;
        cyc.data = req_reg.data;
      end
      if (step_reg == 3'h5) begin
        if (req_reg.op == fmh_pkg::OP_CHIP_ERASE) begin
          cyc.data = fmh_cmd(fmh_pkg::CMD_CHIP_ERASE);
        end else begin
          // Block chosen by upper address bits only
          cyc.addr = {req_reg.addr[fmh_pkg::ADDR_W-1 -: fmh_pkg::BLOCK_SEL_W],
                      {fmh_pkg::BLOCK_SEL_LSB{1'b0}}};
          cyc.data = fmh_cmd(fmh_pkg::CMD_SECTOR_ERASE);
        end
      end
    end
  end

  assign REQ_READY = (state_reg == HS_IDLE);
  assign cyc_start = (state_reg == HS_ISSUE);

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= HS_IDLE;
      step_reg  <= 3'h0;
      req_reg   <= '0;
    end else begin
      unique case (state_reg)
        HS_IDLE: begin
          if (REQ_VALID) begin
            req_reg   <= REQ;
            step_reg  <= 3'h0;
            state_reg <= HS_ISSUE;
          end
        end
        HS_ISSUE: state_reg <= HS_WAIT;
        HS_WAIT: begin
          if (cyc_done) begin
            if (step_reg == steps - 3'h1) begin
              state_reg <= HS_DONE;
            end else begin
              step_reg  <= step_reg + 3'h1;
              state_reg <= HS_ISSUE;
            end
          end
        end
        HS_DONE: state_reg <= HS_IDLE;
      endcase
    end
  end

  // Program and erase set BUSY; a read reset or suspend request clears it when taken, any other request when it completes
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_reg <= 1'b0;
    end else if (state_reg == HS_DONE) begin
      busy_reg <= (req_reg.op == fmh_pkg::OP_PROGRAM)
               || (req_reg.op == fmh_pkg::OP_SECTOR_ERASE)
               || (req_reg.op == fmh_pkg::OP_CHIP_ERASE);
    end else if (state_reg == HS_IDLE && REQ_VALID
                 && (REQ.op == fmh_pkg::OP_READ_RESET || REQ.op == fmh_pkg::OP_SUSPEND)) begin
      busy_reg <= 1'b0;
    end
  end
  assign BUSY = busy_reg;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      RSP_VALID <= 1'b0;
      RSP_DATA  <= 32'h0000_0000;
    end else begin
      RSP_VALID <= (state_reg == HS_DONE);
      if (cyc_done && !cyc.write) begin
        RSP_DATA <= cyc_rdata;
      end
    end
  end

  fmh_cycle u_cycle (
    .clk     (CLOCK),
    .rst_n   (RESET_N),
    .start   (cyc_start),
    .cyc     (cyc),
    .dq_in   (DQ_IN),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .addr_o  (ADDR),
    .dq_out  (DQ_OUT),
    .dq_oe_n (DQ_OE_N),
    .sel_n   (DIE_SELECT_N_PAIR),
    .we_n    (WRITE_N),
    .oe_n    (GATE_N)
  );
endmodule : fmh_host
`default_nettype wire

// *** fmh_host_checker.sv ***
// Pin protocol assertions for the flash module host controller
`timescale 1ns/10ps
`default_nettype none
module fmh_host_checker (
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  input wire logic        REQ_READY,
  input wire logic        RSP_VALID,
  input wire logic [19:0] ADDR,
  input wire logic [31:0] DQ_OUT,
  input wire logic        DQ_OE_N,
  input wire logic [1:0]  DIE_SELECT_N_PAIR,
  input wire logic        WRITE_N,
  input wire logic        GATE_N
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  wire idle = &DIE_SELECT_N_PAIR;

  AST_WR_DRIVES: assert property (!WRITE_N |-> !DQ_OE_N && GATE_N && !idle)
    else $error("write strobe without data drive or select");
  AST_GATE_FLOATS: assert property (!GATE_N |-> DQ_OE_N && WRITE_N && !idle)
    else $error("output gate low while host drives data");
  AST_WR_LEN: assert property ($fell(WRITE_N) |-> !WRITE_N [*4] ##1 WRITE_N)
    else $error("write strobe width wrong");
  AST_GATE_LEN: assert property ($fell(GATE_N) |-> !GATE_N [*4] ##1 GATE_N)
    else $error("output gate width wrong");
  AST_ADDR_HOLD: assert property (!WRITE_N |-> $stable(ADDR) && $stable(DQ_OUT))
    else $error("address or data moved during write strobe");
  AST_SEL_HOLD: assert property (!(WRITE_N && GATE_N) |-> $stable(DIE_SELECT_N_PAIR))
    else $error("select moved during strobe");
  AST_BUSY_READY: assert property (!idle |-> !REQ_READY)
    else $error("ready while a die is selected");
  AST_IDLE_QUIET: assert property (idle |-> WRITE_N && GATE_N)
    else $error("strobe active while deselected");
  AST_RSP_AFTER: assert property (RSP_VALID |-> idle ##1 !RSP_VALID)
    else $error("answer before cycle closed or too long");

  COV_READ: cover property ($fell(GATE_N));
  COV_WRITE: cover property ($fell(WRITE_N));
  COV_WIDE: cover property (DIE_SELECT_N_PAIR == 2'b00 && !GATE_N);
  COV_X16: cover property (DIE_SELECT_N_PAIR == 2'b01 && !GATE_N);
endmodule : fmh_host_checker

bind fmh_host fmh_host_checker chk_u (.CLOCK, .RESET_N, .REQ_READY, .RSP_VALID, .ADDR,
  .DQ_OUT, .DQ_OE_N, .DIE_SELECT_N_PAIR, .WRITE_N, .GATE_N);
`default_nettype wire

// *** fmh_flash_model.sv ***
// Behavioural model of the two-die flash module
`timescale 1ns/10ps
`default_nettype none
module fmh_flash_model #(
  parameter logic [15:0] MAN_ID = 16'h00A5, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h005C  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic [19:0] addr,
  input  wire logic [31:0] din,
  input  wire logic [1:0]  sel_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  output logic [31:0]      dout
);
  localparam int DIE_SPAN = 32'h0010_0000; // Two 16-bit dies
  logic [15:0] mem [int];
  int          st [2] = '{0, 0};
  bit          idm [2] = '{0, 0}; // Power-up in array read, ID mode off
  logic [15:0] junk = 16'h5A5A;

  // Undriven lines toggle so stale data never looks valid
  always @(posedge clk) junk <= ~junk;

  task automatic cmd(input int d, input logic [7:0] c, input logic [15:0] w);
    case (st[d])
      0: st[d] = (addr == 20'h0_5555 && c == 8'hAA) ? 1 : 0;
      1: st[d] = (addr == 20'h0_2AAA && c == 8'h55) ? 2 : 0;
      2: begin
        st[d] = (c == 8'hA0) ? 3 : (c == 8'h80) ? 4 : 0;
        if (c == 8'h90 || c == 8'hF0) idm[d] = (c == 8'h90);
      end
      // Operations finish at once, so no command waits behind them
      3: begin
        mem[d * DIE_SPAN + int'(addr)] = w;
        st[d] = 0;
      end
      4: st[d] = (c == 8'hAA) ? 5 : 0;
      5: st[d] = (c == 8'h55) ? 6 : 0;
      default: begin
        foreach (mem[i]) if (i / DIE_SPAN == d && (c == 8'h10 || (c == 8'h30 &&
            i[19:16] == addr[19:16]))) mem[i] = 16'hFFFF;
        st[d] = 0;
      end
    endcase
  endtask : cmd

  // Address and command taken from the pins at each write strobe
  always @(negedge we_n) begin
    #1;
    for (int d = 0; d < 2; d++) if (!sel_n[d]) cmd(d, din[16*d +: 8], din[16*d +: 16]);
  end

  always @(negedge clk) begin
    for (int d = 0; d < 2; d++) begin
      if (sel_n[d] || oe_n) dout[16*d +: 16] <= junk;
      else if (idm[d]) dout[16*d +: 16] <= addr[0] ? DEV_ID : MAN_ID;
      else if (mem.exists(d * DIE_SPAN + int'(addr))) dout[16*d +: 16] <= mem[d * DIE_SPAN + int'(addr)];
      else dout[16*d +: 16] <= 16'hFFFF;
    end
  end
endmodule : fmh_flash_model
`default_nettype wire

// *** fmh_host_tb_top.sv ***
// Self-checking testbench for the flash module host controller
`timescale 1ns/10ps
`default_nettype none
module fmh_host_tb_top;
  localparam logic [15:0] MAN_ID = 16'h00A5; // Arbitrary value
  localparam logic [15:0] DEV_ID = 16'h005C; // Arbitrary value
  localparam int          SPAN   = 32'h0010_0000;
  logic clock = 1'b0, reset_n = 1'b0, req_valid = 1'b0;
  fmh_pkg::fmh_req_s req = '0;
  logic req_ready, rsp_valid, busy, dq_oe_n, write_n, gate_n;
  logic [31:0] rsp_data, dq_out, dev_q, seed = 32'hFAE5_9BD2;
  logic [19:0] addr;
  logic [1:0]  sel_n;
  logic [19:0] q [$];
  logic [15:0] exp [int];
  int fails = 0, num_checks = 0, cyc = 0;
  wire [31:0] dq_bus = !dq_oe_n ? dq_out : dev_q;

  always #20 clock = ~clock;

  fmh_host dut_u (.CLOCK(clock), .RESET_N(reset_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ(req), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .BUSY(busy), .ADDR(addr),
    .DQ_IN(dq_bus), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .DIE_SELECT_N_PAIR(sel_n),
    .WRITE_N(write_n), .GATE_N(gate_n));
  fmh_flash_model #(.MAN_ID(MAN_ID), .DEV_ID(DEV_ID)) dev_u (.clk(clock), .addr(addr),
    .din(dq_bus), .sel_n(sel_n), .we_n(write_n), .oe_n(gate_n), .dout(dev_q));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] ev(input int k);
    return exp.exists(k) ? exp[k] : 16'hFFFF;
  endfunction : ev

  task automatic report_and_stop;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : check

  // Issue one request and wait for its answer; returns just after an edge
  task automatic op(input fmh_pkg::fmh_op_e o, input logic w, input logic d,
                    input logic [19:0] a, input logic [31:0] v);
    req <= '{o, w, d, a, v};
    req_valid <= 1'b1;
    @(negedge clock);
    while (req_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1) @(negedge clock);
    @(posedge clock);
  endtask : op

  task automatic rd(input logic [19:0] a);
    op(fmh_pkg::OP_READ, 1'b1, 1'b0, a, '0);
    check(rsp_data, {ev(int'(a) + SPAN), ev(int'(a))});
  endtask : rd

  // Raw command write, byte placed on both die halves
  task automatic wr(input logic [19:0] a, input logic [7:0] c);
    op(fmh_pkg::OP_WRITE, 1'b1, 1'b0, a, {8'h00, c, 8'h00, c});
  endtask : wr

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    check(32'({sel_n, write_n, gate_n, dq_oe_n}), 32'h0000_001F);
    @(posedge clock);
    rd(20'h0_1234);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      q.push_back(seed[19:0]);
      seed = lfsr(seed);
      op(fmh_pkg::OP_PROGRAM, 1'b1, 1'b0, q[i], seed);
      exp[int'(q[i])] = seed[15:0];
      exp[int'(q[i]) + SPAN] = seed[31:16];
      check(32'(busy), 32'h0000_0001);
      op(fmh_pkg::OP_READ_RESET, 1'b1, 1'b0, '0, '0);
      check(32'(busy), 32'h0000_0000);
      rd(q[i]);
    end
    op(fmh_pkg::OP_READ_ID, 1'b1, 1'b0, '0, '0);
    op(fmh_pkg::OP_READ, 1'b1, 1'b0, 20'h0_0000, '0);
    check(rsp_data, {MAN_ID, MAN_ID});
    op(fmh_pkg::OP_READ, 1'b1, 1'b0, 20'h0_0001, '0);
    check(rsp_data, {DEV_ID, DEV_ID});
    op(fmh_pkg::OP_READ_RESET, 1'b1, 1'b0, '0, '0);
    op(fmh_pkg::OP_SECTOR_ERASE, 1'b0, 1'b0, q[0], '0);
    check(32'(busy), 32'h0000_0001);
    op(fmh_pkg::OP_SUSPEND, 1'b0, 1'b0, '0, '0);
    check(32'(busy), 32'h0000_0000);
    foreach (exp[k]) if (k < SPAN && k[19:16] == q[0][19:16]) exp[k] = 16'hFFFF;
    foreach (q[i]) rd(q[i]);
    op(fmh_pkg::OP_CHIP_ERASE, 1'b0, 1'b1, '0, '0);
    op(fmh_pkg::OP_READ_RESET, 1'b1, 1'b0, '0, '0);
    foreach (exp[k]) if (k >= SPAN) exp[k] = 16'hFFFF;
    foreach (q[i]) rd(q[i]);
    // Program sequence built by hand from raw single writes
    seed = lfsr(seed);
    wr(fmh_pkg::UNLOCK_ADDR_1, fmh_pkg::UNLOCK_DATA_1);
    wr(fmh_pkg::UNLOCK_ADDR_2, fmh_pkg::UNLOCK_DATA_2);
    wr(fmh_pkg::UNLOCK_ADDR_1, fmh_pkg::CMD_PROGRAM);
    op(fmh_pkg::OP_WRITE, 1'b1, 1'b0, q[1], seed);
    check(32'(busy), 32'h0000_0000);
    exp[int'(q[1])] = seed[15:0];
    exp[int'(q[1]) + SPAN] = seed[31:16];
    rd(q[1]);
    // Single die read: only the selected half is defined
    op(fmh_pkg::OP_READ, 1'b0, 1'b1, q[1], '0);
    check(32'(rsp_data[31:16]), 32'(ev(int'(q[1]) + SPAN)));
    report_and_stop();
  end
endmodule : fmh_host_tb_top
`default_nettype wire
